// File: bad_map.svh
// Address map, field positions and reset values for the board decoder
`ifndef BAD_MAP_SVH
`define BAD_MAP_SVH

`define BAD_ADDR_W         24
`define BAD_IO_W           10
`define BAD_DATA_W         8
`define BAD_IO_SEL_N       7

// Memory regions, inclusive bounds
`define BAD_SYS_DRAM_LO    24'h000000
`define BAD_SYS_DRAM_HI    24'h09FFFF
`define BAD_FLASH_WIN_LO   24'h0B0000
`define BAD_FLASH_WIN_HI   24'h0B7FFF
`define BAD_VID_BIOS_LO    24'h0C0000
`define BAD_VID_BIOS_HI    24'h0CBFFF
`define BAD_SRAM_WIN_LO    24'h0DC000
`define BAD_SRAM_WIN_HI    24'h0DFFFF
`define BAD_SYS_BIOS_LO    24'h0E0000
`define BAD_SYS_BIOS_HI    24'h0FFFFF
`define BAD_EXT_DRAM_LO    24'h100000
`define BAD_EXT_DRAM_HI    24'h3FFFFF
`define BAD_BIG_DRAM_LO    24'h400000
`define BAD_BIG_DRAM_HI    24'hFFFFFF

// Flash and SRAM window geometry
`define BAD_FLASH_OFS_W    15
`define BAD_FLASH_ADDR_W   23
`define BAD_SRAM_OFS_W     14

// I/O regions, inclusive bounds on the low ten address bits
`define BAD_IO_ALT_RESET   10'h0EF
`define BAD_IO_ADDR_GATE   10'h0EE
`define BAD_IO_SETUP_LO    10'h022
`define BAD_IO_SETUP_HI    10'h023
`define BAD_IO_TIMER_LO    10'h040
`define BAD_IO_TIMER_HI    10'h043
`define BAD_IO_GENERAL_LO  10'h080
`define BAD_IO_GENERAL_HI  10'h08F
`define BAD_IO_PAGE_LO     10'h2A0
`define BAD_IO_PAGE_HI     10'h2A1

// Index of each I/O select
`define BAD_IOS_RESET      0
`define BAD_IOS_GATE       1
`define BAD_IOS_SETUP      2
`define BAD_IOS_TIMER      3
`define BAD_IOS_GENERAL    4
`define BAD_IOS_PAGE_LO    5
`define BAD_IOS_PAGE_HI    6

// Index of each memory window in the decode table
`define BAD_MEM_RG_N       7
`define BAD_MRG_SYS_DRAM   0
`define BAD_MRG_EXT_DRAM   1
`define BAD_MRG_BIG_DRAM   2
`define BAD_MRG_SYS_BIOS   3
`define BAD_MRG_VID_BIOS   4
`define BAD_MRG_SRAM       5
`define BAD_MRG_FLASH      6

`define BAD_PAGE_RST       8'h00

`endif

// File: bad_pkg.sv
// Types shared by the board decoder modules
`include "bad_map.svh"

package bad_pkg;

  typedef logic [`BAD_ADDR_W-1:0]   bad_addr_t;
  typedef logic [`BAD_DATA_W-1:0]   bad_data_t;
  typedef logic [`BAD_IO_SEL_N-1:0] bad_io_sel_t;

  typedef enum logic [0:0] {
    BAD_IDLE,
    BAD_BUSY
  } bad_state_t;

  typedef struct packed {
    logic      cyc;
    logic      mio;
    logic      wr;
    bad_addr_t addr;
    bad_data_t wdata;
  } bad_bus_t;

  typedef struct packed {
    logic dram;
    logic sys_bios;
    logic vid_bios;
    logic sram;
    logic flash;
  } bad_mem_sel_t;

endpackage : bad_pkg

// File: bad_dec_if.sv
// Carrier between the decoder top and its I/O region matcher
`timescale 1ns/1ps
`default_nettype none
`include "bad_map.svh"

interface bad_dec_if;
  import bad_pkg::*;

  logic [`BAD_IO_W-1:0] io_addr;
  bad_io_sel_t          io_sel;

  modport matcher (
    input  io_addr,
    output io_sel
  );

  modport user (
    output io_addr,
    input  io_sel
  );
endinterface : bad_dec_if

`default_nettype wire

// File: bad_io_match.sv
// I/O region matcher on the low ten address bits
`timescale 1ns/1ps
`default_nettype none
`include "bad_map.svh"

module bad_io_match (
  bad_dec_if.matcher dec
);
  import bad_pkg::*;

  localparam logic [`BAD_IO_W-1:0] LO [`BAD_IO_SEL_N] = '{
    `BAD_IO_ALT_RESET, `BAD_IO_ADDR_GATE, `BAD_IO_SETUP_LO,
    `BAD_IO_TIMER_LO, `BAD_IO_GENERAL_LO, `BAD_IO_PAGE_LO,
    `BAD_IO_PAGE_HI};
  localparam logic [`BAD_IO_W-1:0] HI [`BAD_IO_SEL_N] = '{
    `BAD_IO_ALT_RESET, `BAD_IO_ADDR_GATE, `BAD_IO_SETUP_HI,
    `BAD_IO_TIMER_HI, `BAD_IO_GENERAL_HI, `BAD_IO_PAGE_LO,
    `BAD_IO_PAGE_HI};

  // Upper bits never reach here, so every region repeats each 1K
  genvar i;
  generate
    for (i = 0; i < `BAD_IO_SEL_N; i++) begin : g_region
      assign dec.io_sel[i] = (dec.io_addr >= LO[i]) &&
                             (dec.io_addr <= HI[i]);
    end
  endgenerate
endmodule : bad_io_match

`default_nettype wire

// File: bad_top.sv
// Board address decoder: memory and I/O chip selects for the processor bus
//
// What this block does
// - I/O decode compares only address bits 9..0, range 0 to 3FF.
// - Peripherals answer again at every 1K alias over 64K I/O space.
// - Memory 0B0000-0B7FFF goes to flash through a 32KB paging window.
// - I/O 2A0 holds the flash page; 2A1 is latched but never used; software writes them first.
// - Flash activity indicator is active while a flash access is underway.
// - Memory 0DC000-0DFFFF selects a 16K window into battery SRAM.
// - BIOS shadow DRAM at 0E0000-0FFFFF, video BIOS shadow from 0C0000.
// - Memory 100000-3FFFFF selects extended or expanded_memory DRAM.
// - Large build adds 12MB DRAM from 400000; small build leaves it empty.
// - I/O 0EF selects the alternate processor reset control.
// - I/O 0EE selects the alternate high_address_gate control.
// - I/O 022-023 selects the chip_setup_control index/data pair.
// - I/O 040-043 selects the interval_timer.
// - I/O 080-08F selects general and DMA page registers.
`timescale 1ns/1ps
`default_nettype none
`include "bad_map.svh"

module bad_top #(
  parameter bit LARGE_BUILD = 1'b1
) (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic                        bus_cyc,
  input  wire logic                        bus_mio,
  input  wire logic                        bus_wr,
  input  wire bad_pkg::bad_addr_t          bus_addr,
  input  wire bad_pkg::bad_data_t          bus_wdata,
  output var  logic                        sel_dram,
  output var  logic                        sel_sys_bios_shadow,
  output var  logic                        sel_vid_bios_shadow,
  output var  logic                        sel_sram,
  output var  logic [`BAD_SRAM_OFS_W-1:0]  sram_win_addr,
  output var  logic                        sel_flash,
  output var  logic [`BAD_FLASH_ADDR_W-1:0] flash_addr,
  output var  logic                        flash_led,
  output var  logic                        sel_alt_reset,
  output var  logic                        sel_high_address_gate,
  output var  logic                        sel_chip_setup_control,
  output var  logic                        sel_interval_timer,
  output var  logic                        sel_general_regs,
  output var  logic                        sel_expansion,
  output var  logic                        onboard_data_en
);
  import bad_pkg::*;

  localparam int PAGE_W = `BAD_FLASH_ADDR_W - `BAD_FLASH_OFS_W;

  typedef struct packed {
    bad_bus_t                      s1;
    bad_bus_t                      s2;
    bad_state_t                    st;
    bad_mem_sel_t                  mem;
    bad_io_sel_t                   io;
    logic                          ext;
    logic                          data_en;
    bad_data_t                     page_lo;
    bad_data_t                     page_hi;
    logic [`BAD_FLASH_ADDR_W-1:0]  faddr;
    logic [`BAD_SRAM_OFS_W-1:0]    saddr;
    logic                          armed;
  } bad_regs_t;

  bad_regs_t    q;
  bad_regs_t    d;
  bad_mem_sel_t mem_hit;
  logic         io_hit;
  bad_addr_t    a;

  bad_dec_if dec ();

  bad_io_match u_io_match (
    .dec (dec.matcher)
  );

  // Bus pins are asynchronous to sys_clk; decode only the second stage
  assign a           = q.s2.addr;
  assign dec.io_addr = a[`BAD_IO_W-1:0];

  // One table entry per memory window; the small build masks the top DRAM
  localparam int        MEM_N = `BAD_MEM_RG_N;
  localparam bad_addr_t MEM_LO [MEM_N] = '{
    `BAD_SYS_DRAM_LO,
    `BAD_EXT_DRAM_LO,
    `BAD_BIG_DRAM_LO,
    `BAD_SYS_BIOS_LO,
    `BAD_VID_BIOS_LO,
    `BAD_SRAM_WIN_LO,
    `BAD_FLASH_WIN_LO
  };
  localparam bad_addr_t MEM_HI [MEM_N] = '{
    `BAD_SYS_DRAM_HI,
    `BAD_EXT_DRAM_HI,
    `BAD_BIG_DRAM_HI,
    `BAD_SYS_BIOS_HI,
    `BAD_VID_BIOS_HI,
    `BAD_SRAM_WIN_HI,
    `BAD_FLASH_WIN_HI
  };
  localparam bit        MEM_ON [MEM_N] = '{
    1'b1,
    1'b1,
    LARGE_BUILD,
    1'b1,
    1'b1,
    1'b1,
    1'b1
  };

  logic [MEM_N-1:0]     mem_in;

  genvar r;
  generate
    for (r = 0; r < MEM_N; r++) begin : g_mem_region
      assign mem_in[r] = MEM_ON[r] && (a >= MEM_LO[r]) &&
                         (a <= MEM_HI[r]);
    end
  endgenerate

  always_comb begin
    mem_hit          = '0;
    mem_hit.dram     = mem_in[`BAD_MRG_SYS_DRAM] ||
                       mem_in[`BAD_MRG_EXT_DRAM] ||
                       mem_in[`BAD_MRG_BIG_DRAM];
    mem_hit.sys_bios = mem_in[`BAD_MRG_SYS_BIOS];
    mem_hit.vid_bios = mem_in[`BAD_MRG_VID_BIOS];
    mem_hit.sram     = mem_in[`BAD_MRG_SRAM];
    mem_hit.flash    = mem_in[`BAD_MRG_FLASH];
  end

  assign io_hit = |dec.io_sel;

  always_comb begin
    d    = q;
    d.s1 = '{cyc: bus_cyc, mio: bus_mio, wr: bus_wr,
             addr: bus_addr, wdata: bus_wdata};
    d.s2 = q.s1;
    d.armed = q.s2.cyc;
    case (q.st)
      BAD_IDLE: begin
        // Address and strobe move together at the pins, so decode waits
        // one more edge for a second-stage address that is surely settled
        if (q.s2.cyc && q.armed) begin
          d.st = BAD_BUSY;
          // Selects are frozen for the whole cycle so a drifting
          // address cannot glitch a chip select mid-access
          if (q.s2.mio) begin
            d.mem     = mem_hit;
            d.io      = '0;
            d.ext     = ~|mem_hit;
            d.data_en = |mem_hit;
          end else begin
            d.mem     = '0;
            d.io      = dec.io_sel;
            d.ext     = ~io_hit;
            d.data_en = io_hit & ~q.s2.wr;
            if (q.s2.wr && dec.io_sel[`BAD_IOS_PAGE_LO]) begin
              d.page_lo = q.s2.wdata;
            end
            if (q.s2.wr && dec.io_sel[`BAD_IOS_PAGE_HI]) begin
              d.page_hi = q.s2.wdata;
            end
          end
          // Write cycles never drive on-board data back to the bus
          if (q.s2.wr) begin
            d.data_en = 1'b0;
          end
          d.faddr = {q.page_lo[PAGE_W-1:0],
                     a[`BAD_FLASH_OFS_W-1:0]};
          d.saddr = a[`BAD_SRAM_OFS_W-1:0];
        end
      end
      BAD_BUSY: begin
        if (!q.s2.cyc) begin
          d.st      = BAD_IDLE;
          d.mem     = '0;
          d.io      = '0;
          d.ext     = 1'b0;
          d.data_en = 1'b0;
        end
      end
      default: begin
        d.st = BAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.st      <= BAD_IDLE;
      q.page_lo <= `BAD_PAGE_RST;
      q.page_hi <= `BAD_PAGE_RST;
    end else begin
      q <= d;
    end
  end

  // Every output is a plain copy of a state flip-flop
  assign sel_dram               = q.mem.dram;
  assign sel_sys_bios_shadow    = q.mem.sys_bios;
  assign sel_vid_bios_shadow    = q.mem.vid_bios;
  assign sel_sram               = q.mem.sram;
  assign sram_win_addr          = q.saddr;
  assign sel_flash              = q.mem.flash;
  assign flash_addr             = q.faddr;
  assign flash_led              = q.mem.flash;
  assign sel_alt_reset          = q.io[`BAD_IOS_RESET];
  assign sel_high_address_gate  = q.io[`BAD_IOS_GATE];
  assign sel_chip_setup_control = q.io[`BAD_IOS_SETUP];
  assign sel_interval_timer     = q.io[`BAD_IOS_TIMER];
  assign sel_general_regs       = q.io[`BAD_IOS_GENERAL];
  assign sel_expansion          = q.ext;
  assign onboard_data_en        = q.data_en;

endmodule : bad_top

`default_nettype wire

// File: bad_props.sv
// Decoder port assertions
`timescale 1ns/1ps
`default_nettype none
`include "bad_map.svh"
module bad_props (
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic               bus_mio,
  input wire logic               bus_wr,
  input wire bad_pkg::bad_addr_t bus_addr,
  input wire logic               sel_dram,
  input wire logic               sel_sram,
  input wire logic               sel_flash,
  input wire logic [22:0]        flash_addr,
  input wire logic               flash_led,
  input wire logic               sel_alt_reset,
  input wire logic               sel_high_address_gate,
  input wire logic               sel_chip_setup_control,
  input wire logic               sel_interval_timer,
  input wire logic               sel_general_regs,
  input wire logic               sel_expansion,
  input wire logic               onboard_data_en
);
  import bad_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_led; flash_led == sel_flash; endproperty
  a_led: assert property (p_led) else $error("led off flash");
  property p_flash;
    $rose(sel_flash) |-> $past(bus_mio, 2)
      && $past(bus_addr, 2) inside {[24'h0B0000:24'h0B7FFF]};
  endproperty
  a_flash: assert property (p_flash) else $error("flash sel");
  property p_fofs;
    $rose(sel_flash) |-> flash_addr[14:0] == $past(bus_addr[14:0], 2);
  endproperty
  a_fofs: assert property (p_fofs) else $error("flash offset");
  property p_sram;
    $rose(sel_sram) |-> $past(bus_addr, 2) inside {[24'h0DC000:24'h0DFFFF]};
  endproperty
  a_sram: assert property (p_sram) else $error("sram sel");
  property p_dram;
    $rose(sel_dram) |-> $past(bus_mio, 2)
      && !($past(bus_addr, 2) inside {[24'h0A0000:24'h0FFFFF]});
  endproperty
  a_dram: assert property (p_dram) else $error("dram sel");
  property p_rst;
    $rose(sel_alt_reset) |-> !$past(bus_mio, 2)
      && $past(bus_addr[9:0], 2) == 10'h0EF;
  endproperty
  a_rst: assert property (p_rst) else $error("reset sel");
  property p_tmr;
    $rose(sel_interval_timer) |-> !$past(bus_mio, 2)
      && $past(bus_addr[9:2], 2) == 8'h10;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer sel");
  property p_gen;
    $rose(sel_general_regs) |-> $past(bus_addr[9:4], 2) == 6'h08;
  endproperty
  a_gen: assert property (p_gen) else $error("general sel");
  property p_exp;
    sel_expansion |-> !(sel_dram || sel_flash || sel_sram || sel_general_regs);
  endproperty
  a_exp: assert property (p_exp) else $error("expansion clash");
  property p_den; $rose(onboard_data_en) |-> !$past(bus_wr, 2); endproperty
  a_den: assert property (p_den) else $error("data on write");
  property p_gate;
    $rose(sel_high_address_gate) |-> !$past(bus_mio, 2)
      && $past(bus_addr[9:0], 2) == 10'h0EE;
  endproperty
  a_gate: assert property (p_gate) else $error("gate sel");
  property p_setup;
    $rose(sel_chip_setup_control) |-> !$past(bus_mio, 2)
      && $past(bus_addr[9:1], 2) == 9'h011;
  endproperty
  a_setup: assert property (p_setup) else $error("setup sel");
endmodule : bad_props
bind bad_top bad_props bad_props_i (.sys_clk, .arst_n, .bus_mio, .bus_wr,
  .bus_addr, .sel_dram, .sel_sram, .sel_flash, .flash_addr, .flash_led,
  .sel_alt_reset, .sel_high_address_gate, .sel_chip_setup_control,
  .sel_interval_timer, .sel_general_regs, .sel_expansion,
  .onboard_data_en);
`default_nettype wire

// File: bad_cpu_model.sv
// Processor bus master model
`timescale 1ns/1ps
`default_nettype none
module bad_cpu_model (
  input  wire logic               sys_clk,
  output var  logic               bus_cyc,
  output var  logic               bus_mio,
  output var  logic               bus_wr,
  output var  bad_pkg::bad_addr_t bus_addr,
  output var  bad_pkg::bad_data_t bus_wdata
);
  import bad_pkg::*;
  initial begin
    {bus_cyc, bus_mio, bus_wr, bus_addr, bus_wdata} = '0;
  end
  // Everything held for the whole cycle, long past the 4-edge answer
  task automatic start(input logic m, w, input bad_addr_t a, bad_data_t d);
    @(negedge sys_clk);
    {bus_cyc, bus_mio, bus_wr, bus_addr, bus_wdata} = {1'b1, m, w, a, d};
    repeat (6) @(negedge sys_clk);
  endtask : start
  // Released lines flip so a stale address never looks held
  task automatic stop();
    @(negedge sys_clk);
    {bus_cyc, bus_addr, bus_wdata} = {1'b0, ~bus_addr, ~bus_wdata};
    repeat (6) @(negedge sys_clk);
  endtask : stop
endmodule : bad_cpu_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the board decoder
`timescale 1ns/1ps
`default_nettype none
`include "bad_map.svh"
module tb_top;
  import bad_pkg::*;
  logic sys_clk, arst_n, bus_cyc, bus_mio, bus_wr;
  bad_addr_t bus_addr;
  bad_data_t bus_wdata;
  logic sel_dram, sel_sys_bios_shadow, sel_vid_bios_shadow, sel_sram;
  logic sel_flash, flash_led, sel_alt_reset, sel_high_address_gate;
  logic sel_chip_setup_control, sel_interval_timer, sel_general_regs;
  logic sel_expansion, onboard_data_en;
  logic [13:0] sram_win_addr;
  logic [22:0] flash_addr;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc_n = 0;
  wire logic [22:0] sv = {10'h000, sel_dram, sel_sys_bios_shadow,
    sel_vid_bios_shadow, sel_sram, sel_flash, flash_led, sel_alt_reset,
    sel_high_address_gate, sel_chip_setup_control, sel_interval_timer,
    sel_general_regs, sel_expansion, onboard_data_en};
  bad_top bad_top_i (.sys_clk, .arst_n, .bus_cyc, .bus_mio, .bus_wr,
    .bus_addr, .bus_wdata, .sel_dram, .sel_sys_bios_shadow,
    .sel_vid_bios_shadow, .sel_sram, .sram_win_addr, .sel_flash,
    .flash_addr, .flash_led, .sel_alt_reset, .sel_high_address_gate,
    .sel_chip_setup_control, .sel_interval_timer, .sel_general_regs,
    .sel_expansion, .onboard_data_en);
  // Second copy in the small build, to see that no DRAM answers above 4MB
  logic small_dram, small_exp;
  bad_top #(.LARGE_BUILD(1'b0)) bad_top_small_i (.sys_clk, .arst_n,
    .bus_cyc, .bus_mio, .bus_wr, .bus_addr, .bus_wdata,
    .sel_dram(small_dram), .sel_sys_bios_shadow(), .sel_vid_bios_shadow(),
    .sel_sram(), .sram_win_addr(), .sel_flash(), .flash_addr(),
    .flash_led(), .sel_alt_reset(), .sel_high_address_gate(),
    .sel_chip_setup_control(), .sel_interval_timer(), .sel_general_regs(),
    .sel_expansion(small_exp), .onboard_data_en());
  bad_cpu_model bad_cpu_model_i (.sys_clk, .bus_cyc, .bus_mio, .bus_wr,
    .bus_addr, .bus_wdata);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [22:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Selects must clear once the cycle is over
  task automatic acc(input logic m, w, bad_addr_t a, bad_data_t d,
                     logic [12:0] e);
    bad_cpu_model_i.start(m, w, a, d);
    chk(sv, {10'h000, e});
    bad_cpu_model_i.stop();
    chk(sv, 23'h000000);
  endtask : acc
  task automatic t_mem();
    acc(1'b1, 1'b0, 24'h09FFFF, 8'h00, 13'h1001);
    acc(1'b1, 1'b0, 24'h0B0010, 8'h00, 13'h0181);
    acc(1'b1, 1'b0, 24'h0C0000, 8'h00, 13'h0401);
    acc(1'b1, 1'b0, 24'h0DC000, 8'h00, 13'h0201);
    acc(1'b1, 1'b0, 24'h0FFFFF, 8'h00, 13'h0801);
    acc(1'b1, 1'b0, 24'h100000, 8'h00, 13'h1001);
    acc(1'b1, 1'b0, 24'h400000, 8'h00, 13'h1001);
    acc(1'b1, 1'b0, 24'h0B8000, 8'h00, 13'h0002);
    acc(1'b1, 1'b0, 24'h0DBFFF, 8'h00, 13'h0002);
    bad_cpu_model_i.start(1'b1, 1'b0, 24'h7FFFFF, 8'h00);
    chk(sv, 23'h001001);
    chk({21'h0, small_dram, small_exp}, 23'h000001);
    bad_cpu_model_i.stop();
    chk({21'h0, small_dram, small_exp}, 23'h000000);
    bad_cpu_model_i.start(1'b1, 1'b0, 24'h0DEABC, 8'h00);
    chk(sv, 23'h000201);
    chk({9'h0, sram_win_addr}, 23'h002ABC);
    bad_cpu_model_i.stop();
  endtask : t_mem
  task automatic t_io();
    acc(1'b0, 1'b0, 24'h0000EF, 8'h00, 13'h0041);
    acc(1'b0, 1'b0, 24'h00FCEE, 8'h00, 13'h0021);
    acc(1'b0, 1'b0, 24'h000023, 8'h00, 13'h0011);
    acc(1'b0, 1'b0, 24'h004040, 8'h00, 13'h0009);
    acc(1'b0, 1'b0, 24'h000044, 8'h00, 13'h0002);
    acc(1'b0, 1'b0, 24'h00848F, 8'h00, 13'h0005);
    acc(1'b0, 1'b0, 24'h000090, 8'h00, 13'h0002);
  endtask : t_io
  // Page written before the window is used; stray writes must not move it
  task automatic t_page();
    acc(1'b0, 1'b1, 24'h0002A0, 8'h05, 13'h0000);
    acc(1'b0, 1'b1, 24'h0002A1, 8'hAA, 13'h0000);
    acc(1'b0, 1'b1, 24'h000040, 8'h77, 13'h0008);
    acc(1'b1, 1'b1, 24'h0B0000, 8'h11, 13'h0180);
    bad_cpu_model_i.start(1'b1, 1'b0, 24'h0B7FFF, 8'h00);
    chk(flash_addr, {8'h05, 15'h7FFF});
    chk(sv, 23'h000181);
    bad_cpu_model_i.stop();
    chk(sv, 23'h000000);
  endtask : t_page
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(sv, 23'h000000);
    arst_n = 1'b1;
    t_mem();
    t_io();
    t_page();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
